// ### include/charge_seq_pkg.sv
// Constants, register map and state codes for the charge sequencer
package charge_seq_pkg;

  // ==========================================================
  // Clock and filter timing
  localparam int unsigned CLK_PERIOD_NS      = 10;
  localparam int unsigned TERM_FILTER_NS     = 1000000;
  localparam int unsigned RECHARGE_FILTER_NS = 150000;
  // Least times: round up to whole cycles
  localparam int unsigned TERM_FILTER_CYCLES =
    (TERM_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RECHARGE_FILTER_CYCLES =
    (RECHARGE_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ==========================================================
  // Register map (byte addresses)
  localparam logic [7:0] CTRL_ADDR   = 8'h00;
  localparam logic [7:0] STATUS_ADDR = 8'h04;
  localparam logic [7:0] CYCLES_ADDR = 8'h08;
  localparam int unsigned ADDR_BITS  = 8;

  // CTRL fields
  localparam int unsigned CTRL_ENABLE_BIT = 0;
  localparam logic        CTRL_ENABLE_RST = 1'b1;

  // STATUS fields
  localparam int unsigned STAT_STATE_LSB    = 0;
  localparam int unsigned STAT_READY_BIT    = 8;
  localparam int unsigned STAT_LOCKOUT_BIT  = 9;
  localparam int unsigned STAT_THERMAL_BIT  = 10;
  localparam int unsigned STAT_RECHARGE_BIT = 11;
  localparam int unsigned STAT_LEVEL_LSB    = 12;

  // ==========================================================
  // Commanded current levels
  localparam logic [1:0] LEVEL_OFF   = 2'h0;
  localparam logic [1:0] LEVEL_TENTH = 2'h1;
  localparam logic [1:0] LEVEL_FULL  = 2'h2;

  // Comparator input vector positions
  localparam int unsigned CMP_SUPPLY_RISE  = 0;
  localparam int unsigned CMP_SUPPLY_FALL  = 1;
  localparam int unsigned CMP_MARGIN_HIGH  = 2;
  localparam int unsigned CMP_MARGIN_LOW   = 3;
  localparam int unsigned CMP_ABOVE_TRICK  = 4;
  localparam int unsigned CMP_NEAR_FLOAT   = 5;
  localparam int unsigned CMP_PROG_LOW     = 6;
  localparam int unsigned CMP_PROG_FLOAT   = 7;
  localparam int unsigned CMP_BELOW_RECHG  = 8;
  localparam int unsigned CMP_DIE_HOT      = 9;
  localparam int unsigned CMP_BATT_PRESENT = 10;
  localparam int unsigned CMP_COUNT        = 11;

  // ==========================================================
  // Sequencer states, one-hot
  typedef enum logic [5:0] {
    ST_SHUTDOWN = 6'h01,
    ST_LOCKOUT  = 6'h02,
    ST_TRICKLE  = 6'h04,
    ST_CC       = 6'h08,
    ST_CV       = 6'h10,
    ST_STANDBY  = 6'h20
  } seq_state_type;

endpackage

// ### hw/charge_seq.sv
// Two-cell linear charger sequencer with AHB-Lite register access
//
// How it works
// - Cycle starts on supply ok with resistor/battery
// - Battery under 5.8V selects trickle charge
// - Trickle commands one tenth of current
// - Above 5.8V moves trickle to constant current
// - Near 8.4V float enters constant voltage
// - Program pin low over 1ms terminates
// - Termination latches current off, enters standby
// - No termination in trickle or thermal limit
// - Standby ignores program pin below 2.15V
// - Battery below 8.1V for 150us recharges
// - Status strong pull-down during charge cycle
// - Status weak pull-down when ready
// - Status high impedance during supply lockout
// - Lockout holds shutdown, 150mV hysteresis
// - Enter at 30mV margin, leave at 60mV
// - Floating program pin forces shutdown, reconnect restarts
// - Manual shutdown status follows lockout state
// - Recharge cycle shows strong pull-down
// - Die over 125C flags thermal, current level unchanged
`timescale 1ns/100ps

module charge_seq
  import charge_seq_pkg::*;
#(
  parameter int unsigned TERM_CYCLES     = TERM_FILTER_CYCLES,
  parameter int unsigned RECHARGE_CYCLES = RECHARGE_FILTER_CYCLES
)
(
  // Clock and reset
  input  wire logic        REF_CLK,
  input  wire logic        SYS_RST,
  // AHB-Lite slave
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic             HREADYOUT,
  output logic [31:0]      HRDATA,
  output logic             HRESP,
  // Comparator results (asynchronous)
  input  wire logic        SUPPLY_ABOVE_RISE,
  input  wire logic        SUPPLY_ABOVE_FALL,
  input  wire logic        MARGIN_ABOVE_HIGH,
  input  wire logic        MARGIN_ABOVE_LOW,
  input  wire logic        BATT_ABOVE_TRICKLE,
  input  wire logic        BATT_NEAR_FLOAT,
  input  wire logic        PROG_BELOW_TERM,
  input  wire logic        PROG_FLOATING,
  input  wire logic        BATT_BELOW_RECHARGE,
  input  wire logic        DIE_HOT,
  input  wire logic        BATT_PRESENT,
  // Charge control outputs
  output logic             CHARGE_ON,
  output logic [1:0]       CURRENT_LEVEL,
  output logic             VOLTAGE_MODE,
  output logic             THERMAL_LIMIT,
  // Charge status pin: drive low, weak or released
  output logic             CHARGE_STATUS_OUT,
  output logic             CHARGE_STATUS_OE_N,
  output logic             CHARGE_STATUS_WEAK
);

  localparam int unsigned TERM_W  = $clog2(TERM_CYCLES + 1);
  localparam int unsigned RECH_W  = $clog2(RECHARGE_CYCLES + 1);
  localparam logic [TERM_W-1:0] TERM_LAST =
    TERM_W'(TERM_CYCLES - 1);
  localparam logic [RECH_W-1:0] RECH_LAST =
    RECH_W'(RECHARGE_CYCLES - 1);

  // ==========================================================
  // Input synchronisers
  logic [CMP_COUNT-1:0] cmp_raw;
  logic [CMP_COUNT-1:0] cmp_meta_q;
  logic [CMP_COUNT-1:0] cmp_q;
  logic                 batt_seen_q;

  assign cmp_raw = {BATT_PRESENT, DIE_HOT, BATT_BELOW_RECHARGE,
                    PROG_FLOATING, PROG_BELOW_TERM, BATT_NEAR_FLOAT,
                    BATT_ABOVE_TRICKLE, MARGIN_ABOVE_LOW,
                    MARGIN_ABOVE_HIGH, SUPPLY_ABOVE_FALL,
                    SUPPLY_ABOVE_RISE};

  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
    begin
      cmp_meta_q <= '0;
      cmp_q      <= '0;
    end
    else
    begin
      cmp_meta_q <= cmp_raw;
      cmp_q      <= cmp_meta_q;
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
      batt_seen_q <= 1'b0;
    else
      batt_seen_q <= cmp_q[CMP_BATT_PRESENT];
  end

  logic batt_attach;
  logic prog_float;
  logic die_hot;

  assign batt_attach = cmp_q[CMP_BATT_PRESENT] & ~batt_seen_q;
  assign prog_float  = cmp_q[CMP_PROG_FLOAT];
  assign die_hot     = cmp_q[CMP_DIE_HOT];

  // ==========================================================
  // Supply lockout with hysteresis
  logic supply_ok_q;
  logic margin_ok_q;
  logic lockout;

  // Set above rising threshold, clear only below the lower one
  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
      supply_ok_q <= 1'b0;
    else if (cmp_q[CMP_SUPPLY_RISE])
      supply_ok_q <= 1'b1;
    else if (!cmp_q[CMP_SUPPLY_FALL])
      supply_ok_q <= 1'b0;
  end

  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
      margin_ok_q <= 1'b0;
    else if (cmp_q[CMP_MARGIN_HIGH])
      margin_ok_q <= 1'b1;
    else if (!cmp_q[CMP_MARGIN_LOW])
      margin_ok_q <= 1'b0;
  end

  assign lockout = ~(supply_ok_q & margin_ok_q);

  // ==========================================================
  // Register file
  logic        enable_q;
  logic [31:0] cycles_q;
  logic        wr_pend_q;
  logic [7:0]  wr_addr_q;
  logic        addr_phase;

  assign addr_phase = HSEL & HTRANS[1] & HREADY;

  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
    begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end
    else if (HREADY)
    begin
      wr_pend_q <= addr_phase & HWRITE;
      wr_addr_q <= HADDR[ADDR_BITS-1:0];
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
      enable_q <= CTRL_ENABLE_RST;
    else if (wr_pend_q && wr_addr_q == CTRL_ADDR)
      enable_q <= HWDATA[CTRL_ENABLE_BIT];
  end

  // ==========================================================
  // Sequencer
  seq_state_type     state_q;
  seq_state_type     state_d;
  logic              recharge_q;
  logic [TERM_W-1:0] term_cnt_q;
  logic [RECH_W-1:0] rech_cnt_q;
  logic              term_check;
  logic              term_done;
  logic              rech_done;
  logic              start_ok;
  logic              charging;

  assign charging = (state_q == ST_TRICKLE) | (state_q == ST_CC) |
                    (state_q == ST_CV);

  // Filter runs only in constant voltage and without thermal limit
  assign term_check = (state_q == ST_CV) & ~die_hot &
                      cmp_q[CMP_PROG_LOW];
  assign term_done  = term_check & (term_cnt_q == TERM_LAST);

  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
      term_cnt_q <= '0;
    else if (!term_check)
      term_cnt_q <= '0;
    else if (!term_done)
      term_cnt_q <= term_cnt_q + 1'b1;
  end

  assign rech_done = (state_q == ST_STANDBY) &
                     cmp_q[CMP_BELOW_RECHG] &
                     (rech_cnt_q == RECH_LAST);

  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
      rech_cnt_q <= '0;
    else if (state_q != ST_STANDBY || !cmp_q[CMP_BELOW_RECHG])
      rech_cnt_q <= '0;
    else if (!rech_done)
      rech_cnt_q <= rech_cnt_q + 1'b1;
  end

  assign start_ok = ~prog_float & ~lockout & enable_q;

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_SHUTDOWN:
        if (lockout)
          state_d = ST_LOCKOUT;
        else if (start_ok)
          state_d = cmp_q[CMP_ABOVE_TRICK] ? ST_CC : ST_TRICKLE;
      ST_LOCKOUT:
        if (start_ok)
          state_d = cmp_q[CMP_ABOVE_TRICK] ? ST_CC : ST_TRICKLE;
        else if (!lockout)
          state_d = ST_SHUTDOWN;
      ST_TRICKLE:
        if (cmp_q[CMP_ABOVE_TRICK])
          state_d = ST_CC;
      ST_CC:
        if (cmp_q[CMP_NEAR_FLOAT])
          state_d = ST_CV;
      ST_CV:
        if (term_done)
          state_d = ST_STANDBY;
      ST_STANDBY:
        // Program pin below shutdown threshold has no effect here
        if (rech_done || batt_attach)
          state_d = cmp_q[CMP_ABOVE_TRICK] ? ST_CC : ST_TRICKLE;
      default:
        state_d = ST_SHUTDOWN;
    endcase
    // Lockout and manual shutdown take priority from any state
    if (lockout && state_q != ST_LOCKOUT)
      state_d = ST_LOCKOUT;
    else if (!lockout && (prog_float || !enable_q))
      state_d = ST_SHUTDOWN;
  end

  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
      state_q <= ST_SHUTDOWN;
    else
      state_q <= state_d;
  end

  // Marks a cycle entered from standby by the recharge filter
  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
      recharge_q <= 1'b0;
    else if (state_q == ST_STANDBY && state_d != ST_STANDBY)
      recharge_q <= rech_done & (state_d != ST_LOCKOUT) &
                    (state_d != ST_SHUTDOWN);
    else if (state_q != ST_STANDBY && !charging)
      recharge_q <= 1'b0;
  end

  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
      cycles_q <= 32'h0000_0000;
    else if (!charging && (state_d == ST_TRICKLE || state_d == ST_CC))
      cycles_q <= cycles_q + 32'h0000_0001;
  end

  // ==========================================================
  // Charge control and status pin
  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
    begin
      CHARGE_ON     <= 1'b0;
      CURRENT_LEVEL <= LEVEL_OFF;
      VOLTAGE_MODE  <= 1'b0;
      THERMAL_LIMIT <= 1'b0;
    end
    else
    begin
      CHARGE_ON     <= charging;
      VOLTAGE_MODE  <= (state_q == ST_CV);
      THERMAL_LIMIT <= charging & die_hot;
      if (state_q == ST_TRICKLE)
        CURRENT_LEVEL <= LEVEL_TENTH;
      else if (charging)
        CURRENT_LEVEL <= LEVEL_FULL;
      else
        CURRENT_LEVEL <= LEVEL_OFF;
    end
  end

  // Pin starts released; pull-down only once lockout is evaluated
  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
    begin
      CHARGE_STATUS_OUT  <= 1'b0;
      CHARGE_STATUS_OE_N <= 1'b1;
      CHARGE_STATUS_WEAK <= 1'b0;
    end
    else if (charging)
    begin
      CHARGE_STATUS_OE_N <= 1'b0;
      CHARGE_STATUS_WEAK <= 1'b0;
    end
    else if (lockout)
    begin
      CHARGE_STATUS_OE_N <= 1'b1;
      CHARGE_STATUS_WEAK <= 1'b0;
    end
    else
    begin
      CHARGE_STATUS_OE_N <= 1'b0;
      CHARGE_STATUS_WEAK <= 1'b1;
    end
  end

  // ==========================================================
  // AHB read path, data captured at the address phase
  logic [31:0] status_word;

  always_comb
  begin
    status_word = 32'h0000_0000;
    status_word[STAT_STATE_LSB +: 6] = state_q;
    status_word[STAT_READY_BIT]      = ~lockout & ~charging;
    status_word[STAT_LOCKOUT_BIT]    = lockout;
    status_word[STAT_THERMAL_BIT]    = THERMAL_LIMIT;
    status_word[STAT_RECHARGE_BIT]   = recharge_q;
    status_word[STAT_LEVEL_LSB +: 2] = CURRENT_LEVEL;
  end

  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
      HRDATA <= 32'h0000_0000;
    else if (addr_phase && !HWRITE)
      case (HADDR[ADDR_BITS-1:0])
        CTRL_ADDR:   HRDATA <= {31'h0000_0000, enable_q};
        STATUS_ADDR: HRDATA <= status_word;
        CYCLES_ADDR: HRDATA <= cycles_q;
        default:     HRDATA <= 32'h0000_0000;
      endcase
  end

  // Zero wait states, always OKAY
  assign HREADYOUT = 1'b1;
  assign HRESP     = 1'b0;

endmodule

// ### verification/charge_seq_props.sv
// Port checker for the charge sequencer, bound into the design
`timescale 1ns/100ps
module charge_seq_props
  import charge_seq_pkg::*;
#(
  parameter int unsigned TERM_CYCLES     = 20,
  parameter int unsigned RECHARGE_CYCLES = 10
)
(
  // Clock and reset
  input wire logic       REF_CLK,
  input wire logic       SYS_RST,
  // Comparator results
  input wire logic       SUPPLY_ABOVE_FALL,
  input wire logic       MARGIN_ABOVE_LOW,
  input wire logic       PROG_BELOW_TERM,
  input wire logic       PROG_FLOATING,
  input wire logic       DIE_HOT,
  // Charge control and status pin
  input wire logic       CHARGE_ON,
  input wire logic [1:0] CURRENT_LEVEL,
  input wire logic       VOLTAGE_MODE,
  input wire logic       THERMAL_LIMIT,
  input wire logic       CHARGE_STATUS_OUT,
  input wire logic       CHARGE_STATUS_OE_N,
  input wire logic       CHARGE_STATUS_WEAK
);
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (SYS_RST);

  // ==========================================================
  // Raw run length of a low program pin, saturating
  logic [31:0] low_cnt_q;
  always_ff @(posedge REF_CLK)
    if (SYS_RST || !PROG_BELOW_TERM)
      low_cnt_q <= 32'h0;
    else if (low_cnt_q != 32'hFFFFFFFF)
      low_cnt_q <= low_cnt_q + 32'h1;

  // ==========================================================
  // Assertions
  a_charge_strong: assert property (
    CHARGE_ON |-> !CHARGE_STATUS_OE_N && !CHARGE_STATUS_WEAK)
    else $error("status not strong while charging");
  a_pin_low: assert property (!CHARGE_STATUS_OUT)
    else $error("status pin drives high");
  a_off_level: assert property (
    !CHARGE_ON |-> CURRENT_LEVEL == LEVEL_OFF)
    else $error("current commanded while off");
  a_cv_full: assert property (
    VOLTAGE_MODE |-> CHARGE_ON && CURRENT_LEVEL == LEVEL_FULL)
    else $error("voltage mode without full current");
  a_hot_flag: assert property (
    (CHARGE_ON && DIE_HOT) [*5] ##1 CHARGE_ON |-> THERMAL_LIMIT)
    else $error("thermal limit missing");
  a_lock_hiz: assert property (
    (!SUPPLY_ABOVE_FALL || !MARGIN_ABOVE_LOW) [*5] |=> CHARGE_STATUS_OE_N)
    else $error("status driven in lockout");
  a_float_off: assert property (PROG_FLOATING [*5] |=> !CHARGE_ON)
    else $error("charging with floating pin");
  // Filter: standby entry from voltage mode needs a long low run
  a_term_filter: assert property (
    $fell(CHARGE_ON) && $past(VOLTAGE_MODE) && CHARGE_STATUS_WEAK
    && !CHARGE_STATUS_OE_N |-> low_cnt_q >= TERM_CYCLES)
    else $error("termination before filter time");
  // Reset itself is the cause here, so no disable
  a_reset_hiz: assert property (disable iff (1'b0)
    SYS_RST |=> CHARGE_STATUS_OE_N && !CHARGE_ON)
    else $error("reset state wrong");

  c_term: cover property ($fell(CHARGE_ON) && CHARGE_STATUS_WEAK);
  c_start: cover property ($rose(CHARGE_ON));
  c_hot: cover property ($rose(THERMAL_LIMIT));
endmodule

bind charge_seq charge_seq_props #(.TERM_CYCLES(TERM_CYCLES),
  .RECHARGE_CYCLES(RECHARGE_CYCLES)) i_charge_seq_props (
  .REF_CLK(REF_CLK), .SYS_RST(SYS_RST),
  .SUPPLY_ABOVE_FALL(SUPPLY_ABOVE_FALL), .MARGIN_ABOVE_LOW(MARGIN_ABOVE_LOW),
  .PROG_BELOW_TERM(PROG_BELOW_TERM), .PROG_FLOATING(PROG_FLOATING),
  .DIE_HOT(DIE_HOT), .CHARGE_ON(CHARGE_ON), .CURRENT_LEVEL(CURRENT_LEVEL),
  .VOLTAGE_MODE(VOLTAGE_MODE), .THERMAL_LIMIT(THERMAL_LIMIT),
  .CHARGE_STATUS_OUT(CHARGE_STATUS_OUT),
  .CHARGE_STATUS_OE_N(CHARGE_STATUS_OE_N),
  .CHARGE_STATUS_WEAK(CHARGE_STATUS_WEAK));

// ### verification/status_reader.sv
// Status pin reader model on the far side of the sequencer
`timescale 1ns/100ps
module status_reader
(
  // Pin as driven by the sequencer
  input  wire logic       pin_out,
  input  wire logic       pin_oe_n,
  input  wire logic       pin_weak,
  // Reading: 0 strong, 1 weak, 2 released
  output logic [1:0]      pin_read
);
  logic pin_level;

  // Host pull-up sets the level once released
  assign pin_level = pin_oe_n ? 1'b1 : pin_out;

  always_comb
  begin
    if (pin_level !== 1'b0)
      pin_read = 2'h2;
    else if (pin_weak)
      pin_read = 2'h1;
    else
      pin_read = 2'h0;
  end
endmodule

// ### verification/tb_charge_seq.sv
// Self-checking bench for the charge sequencer
`timescale 1ns/100ps
module tb_charge_seq
  import charge_seq_pkg::*;
;
  localparam int TC = 20;
  localparam int RC = 10;

  logic                 REF_CLK;
  logic                 SYS_RST;
  logic                 HSEL;
  logic [31:0]          HADDR;
  logic [1:0]           HTRANS;
  logic                 HWRITE;
  logic [31:0]          HWDATA;
  logic                 HREADYOUT;
  logic [31:0]          HRDATA;
  logic [CMP_COUNT-1:0] cmp_q;
  logic                 st_out;
  logic                 st_oe_n;
  logic                 st_weak;
  logic [1:0]           pin_read;
  logic                 chg_on;
  logic [31:0]          seed_q;
  logic [63:0]          word_q[$];
  logic [1:0]           pinx_q[$];
  int                   fail_count;
  int                   comparisons;
  event                 rd_ev;
  event                 pin_ev;

  charge_seq #(.TERM_CYCLES(TC), .RECHARGE_CYCLES(RC)) i_charge_seq (
    .REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA),
    .HREADY(HREADYOUT), .HREADYOUT(HREADYOUT), .HRDATA(HRDATA), .HRESP(),
    .SUPPLY_ABOVE_RISE(cmp_q[CMP_SUPPLY_RISE]),
    .SUPPLY_ABOVE_FALL(cmp_q[CMP_SUPPLY_FALL]),
    .MARGIN_ABOVE_HIGH(cmp_q[CMP_MARGIN_HIGH]),
    .MARGIN_ABOVE_LOW(cmp_q[CMP_MARGIN_LOW]),
    .BATT_ABOVE_TRICKLE(cmp_q[CMP_ABOVE_TRICK]),
    .BATT_NEAR_FLOAT(cmp_q[CMP_NEAR_FLOAT]),
    .PROG_BELOW_TERM(cmp_q[CMP_PROG_LOW]),
    .PROG_FLOATING(cmp_q[CMP_PROG_FLOAT]),
    .BATT_BELOW_RECHARGE(cmp_q[CMP_BELOW_RECHG]),
    .DIE_HOT(cmp_q[CMP_DIE_HOT]), .BATT_PRESENT(cmp_q[CMP_BATT_PRESENT]),
    .CHARGE_ON(chg_on), .CURRENT_LEVEL(), .VOLTAGE_MODE(), .THERMAL_LIMIT(),
    .CHARGE_STATUS_OUT(st_out), .CHARGE_STATUS_OE_N(st_oe_n),
    .CHARGE_STATUS_WEAK(st_weak));

  status_reader i_status_reader (.pin_out(st_out), .pin_oe_n(st_oe_n),
    .pin_weak(st_weak), .pin_read(pin_read));

  initial
  begin
    REF_CLK = 1'b0;
    forever #5 REF_CLK = ~REF_CLK;
  end

  // ==========================================================
  // Helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic wt(input int n);
    repeat (n) @(posedge REF_CLK);
  endtask

  task automatic sc(input int b, input logic v, input int n);
    @(posedge REF_CLK);
    cmp_q[b] <= v;
    wt(n);
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic rdy();
    int n;
    n = 0;
    do
    begin
      @(posedge REF_CLK);
      n++;
    end
    while (HREADYOUT !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      fail_count++;
      report_and_stop();
    end
  endtask

  // Read compares (data & m) with e when the data phase ends
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [31:0] m,
                     input logic [31:0] e);
    @(posedge REF_CLK);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HWRITE <= w;
    HADDR <= {24'h0, a};
    rdy();
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= d;
    rdy();
    if (!w)
    begin
      word_q.push_back({m, e});
      ->rd_ev;
    end
  endtask

  task automatic pin(input logic [1:0] e);
    @(posedge REF_CLK);
    #1;
    pinx_q.push_back(e);
    ->pin_ev;
  endtask

  // ==========================================================
  // Result watchers
  task automatic cmp_word(input logic [31:0] got);
    logic [63:0] x;
    x = word_q.pop_front();
    comparisons++;
    if ((got & x[63:32]) !== x[31:0])
    begin
      fail_count++;
      $display("[ERR] %0t word %h exp %h", $time, got & x[63:32], x[31:0]);
    end
  endtask

  task automatic cmp_pin(input logic [1:0] got);
    logic [1:0] x;
    x = pinx_q.pop_front();
    comparisons++;
    // Strong pull-down and charging must agree
    if (got !== x || chg_on !== (x == 2'h0))
    begin
      fail_count++;
      $display("[ERR] %0t pin %h exp %h", $time, {chg_on, got},
               {x == 2'h0, x});
    end
  endtask

  always @(rd_ev) cmp_word(HRDATA);
  always @(pin_ev) cmp_pin(pin_read);

  // ==========================================================
  // Main sequence
  initial
  begin
    int         len;
    logic [7:0] ua;
    SYS_RST = 1'b1;
    HSEL = 1'b0;
    HADDR = 32'h0;
    HTRANS = 2'h0;
    HWRITE = 1'b0;
    HWDATA = 32'h0;
    cmp_q = '0;
    seed_q = 32'h0000000C;
    fail_count = 0;
    comparisons = 0;
    wt(2);
    SYS_RST <= 1'b0;
    pin(2'h2);
    bus(1'b0, CTRL_ADDR, 32'h0, 32'h1, 32'h1);
    // Flags start locked out, so shutdown steps on to the lockout state
    bus(1'b0, STATUS_ADDR, 32'h0, 32'h33F, 32'h202);
    sc(CMP_SUPPLY_RISE, 1'b1, 0);
    sc(CMP_SUPPLY_FALL, 1'b1, 8);
    pin(2'h2);
    sc(CMP_MARGIN_LOW, 1'b1, 0);
    sc(CMP_MARGIN_HIGH, 1'b1, 8);
    pin(2'h0);
    bus(1'b0, STATUS_ADDR, 32'h0, 32'h303F, 32'h1004);
    sc(CMP_ABOVE_TRICK, 1'b1, 8);
    bus(1'b0, STATUS_ADDR, 32'h0, 32'h303F, 32'h2008);
    sc(CMP_NEAR_FLOAT, 1'b1, 8);
    bus(1'b0, STATUS_ADDR, 32'h0, 32'h3F, 32'h10);
    repeat (3)
    begin
      len = 1 + int'(seed_q % (TC - 6));
      seed_q = xs(seed_q);
      sc(CMP_PROG_LOW, 1'b1, len);
      sc(CMP_PROG_LOW, 1'b0, 2);
    end
    bus(1'b0, STATUS_ADDR, 32'h0, 32'h3F, 32'h10);
    sc(CMP_DIE_HOT, 1'b1, 0);
    sc(CMP_PROG_LOW, 1'b1, TC + 10);
    bus(1'b0, STATUS_ADDR, 32'h0, 32'h43F, 32'h410);
    sc(CMP_DIE_HOT, 1'b0, TC + 8);
    bus(1'b0, STATUS_ADDR, 32'h0, 32'h3F, 32'h20);
    pin(2'h1);
    sc(CMP_PROG_LOW, 1'b0, 0);
    sc(CMP_PROG_LOW, 1'b1, 8);
    bus(1'b0, STATUS_ADDR, 32'h0, 32'h3F, 32'h20);
    sc(CMP_NEAR_FLOAT, 1'b0, 0);
    sc(CMP_PROG_LOW, 1'b0, 0);
    sc(CMP_BELOW_RECHG, 1'b1, RC - 4);
    sc(CMP_BELOW_RECHG, 1'b0, 6);
    bus(1'b0, STATUS_ADDR, 32'h0, 32'h3F, 32'h20);
    sc(CMP_BELOW_RECHG, 1'b1, RC + 8);
    pin(2'h0);
    bus(1'b0, STATUS_ADDR, 32'h0, 32'h83F, 32'h808);
    sc(CMP_BELOW_RECHG, 1'b0, 0);
    sc(CMP_PROG_FLOAT, 1'b1, 8);
    pin(2'h1);
    bus(1'b0, STATUS_ADDR, 32'h0, 32'h3F, 32'h01);
    // Falling supply crosses the upper margin first
    sc(CMP_MARGIN_HIGH, 1'b0, 0);
    sc(CMP_MARGIN_LOW, 1'b0, 8);
    pin(2'h2);
    sc(CMP_MARGIN_LOW, 1'b1, 0);
    sc(CMP_MARGIN_HIGH, 1'b1, 8);
    pin(2'h1);
    sc(CMP_PROG_FLOAT, 1'b0, 8);
    pin(2'h0);
    sc(CMP_MARGIN_HIGH, 1'b0, 0);
    sc(CMP_MARGIN_LOW, 1'b0, 8);
    pin(2'h2);
    sc(CMP_MARGIN_LOW, 1'b1, 8);
    pin(2'h2);
    sc(CMP_MARGIN_HIGH, 1'b1, 8);
    pin(2'h0);
    sc(CMP_SUPPLY_RISE, 1'b0, 8);
    pin(2'h0);
    sc(CMP_SUPPLY_FALL, 1'b0, 8);
    pin(2'h2);
    sc(CMP_SUPPLY_FALL, 1'b1, 8);
    pin(2'h2);
    sc(CMP_SUPPLY_RISE, 1'b1, 8);
    pin(2'h0);
    bus(1'b1, CTRL_ADDR, 32'h0, 32'h0, 32'h0);
    wt(8);
    bus(1'b0, CTRL_ADDR, 32'h0, 32'h1, 32'h0);
    bus(1'b0, STATUS_ADDR, 32'h0, 32'h3F, 32'h01);
    pin(2'h1);
    ua = {(seed_q[7:4] | 4'h1), 4'h0};
    bus(1'b1, ua, 32'hFFFFFFFF, 32'h0, 32'h0);
    bus(1'b0, ua, 32'h0, 32'hFFFFFFFF, 32'h0);
    bus(1'b1, STATUS_ADDR, 32'hFFFFFFFF, 32'h0, 32'h0);
    bus(1'b0, STATUS_ADDR, 32'h0, 32'h3F, 32'h01);
    bus(1'b1, CTRL_ADDR, 32'h1, 32'h0, 32'h0);
    wt(8);
    pin(2'h0);
    // Terminate once more, then restart by attaching a battery
    sc(CMP_NEAR_FLOAT, 1'b1, 0);
    sc(CMP_PROG_LOW, 1'b1, TC + 8);
    pin(2'h1);
    sc(CMP_BATT_PRESENT, 1'b1, 8);
    pin(2'h0);
    bus(1'b0, CYCLES_ADDR, 32'h0, 32'hFFFFFFFF, 32'h7);
    report_and_stop();
  end
endmodule
